// [include/instr_exec_pkg.sv]
// constants and carrier types for the literal/move/return execute block
package instr_exec_pkg;

  // ************************************************************
  // instruction word layout
  // ************************************************************
  localparam int INSTR_W = 12;
  localparam int DATA_W  = 8;
  localparam int FADDR_W = 5;
  localparam int PC_W    = 9;
  localparam int BIT_W   = 3;
  localparam int FILE_DEPTH = 32;

  // field positions
  localparam int OP4_HI   = 11;
  localparam int OP4_LO   = 8;
  localparam int OP7_LO   = 5;
  localparam int BIDX_HI  = 7;
  localparam int BIDX_LO  = 5;
  localparam int FADDR_HI = 4;
  localparam int LIT_HI   = 7;

  // ************************************************************
  // opcode patterns
  // ************************************************************
  localparam logic [3:0]         OP_AND_LIT   = 4'he;
  localparam logic [3:0]         OP_BIT_CLR   = 4'h4;
  localparam logic [3:0]         OP_RET_CONST = 4'h8;
  localparam logic [6:0]         OP_COPY_ACC  = 7'h01;
  localparam logic [INSTR_W-1:0] OP_IDLE      = 12'h000;
  localparam logic [INSTR_W-1:0] OP_OPT_LOAD  = 12'h002;

  // ************************************************************
  // reset values and timing
  // ************************************************************
  localparam logic [DATA_W-1:0] ACC_RST    = 8'h00;
  localparam logic [DATA_W-1:0] OPTION_RST = 8'hff;
  localparam logic [PC_W-1:0]   PC_RST     = 9'h000;
  localparam int                RET_CYCLES = 2;

  // file register write strobe with its address and data
  typedef struct packed {
    logic               en;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0]  data;
  } file_wr_t;

  // program counter reload request towards the fetch side
  typedef struct packed {
    logic            load;
    logic            pop;
    logic [PC_W-1:0] value;
  } pc_req_t;

  typedef enum logic {
    ST_EXEC,
    ST_FLUSH
  } exec_state_t;

endpackage

// [design/instr_exec.sv]
// execute stage for literal and, bit clear, copy, idle, option load and return
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - literal and into accumulator, zero flag only
// - literal and result never reaches file registers
// - bit clear touches one bit, no flags
// - copy accumulator to file in one cycle
// - return loads literal into accumulator, flags kept
// - return reloads pc from popped stack top
// - return takes two cycles, others one
module instr_exec (
  input  wire logic                                 sys_clk,
  input  wire logic                                 rst_n,
  input  wire logic                                 instr_valid,
  input  wire logic [instr_exec_pkg::INSTR_W-1:0]   instr,
  input  wire logic [instr_exec_pkg::PC_W-1:0]      stack_top,
  output logic                                      busy,
  output logic [instr_exec_pkg::DATA_W-1:0]         acc,
  output logic                                      zero_flag,
  output logic [instr_exec_pkg::DATA_W-1:0]         option_reg,
  output instr_exec_pkg::file_wr_t                  file_wr,
  output instr_exec_pkg::pc_req_t                   pc_req
);

  // ************************************************************
  // decode helpers
  // ************************************************************
  function automatic logic is_and_lit(input logic [instr_exec_pkg::INSTR_W-1:0] w);
    is_and_lit = w[instr_exec_pkg::OP4_HI:instr_exec_pkg::OP4_LO] == instr_exec_pkg::OP_AND_LIT;
  endfunction

  function automatic logic is_bit_clr(input logic [instr_exec_pkg::INSTR_W-1:0] w);
    is_bit_clr = w[instr_exec_pkg::OP4_HI:instr_exec_pkg::OP4_LO] == instr_exec_pkg::OP_BIT_CLR;
  endfunction

  function automatic logic is_ret(input logic [instr_exec_pkg::INSTR_W-1:0] w);
    is_ret = w[instr_exec_pkg::OP4_HI:instr_exec_pkg::OP4_LO] == instr_exec_pkg::OP_RET_CONST;
  endfunction

  function automatic logic is_copy(input logic [instr_exec_pkg::INSTR_W-1:0] w);
    is_copy = w[instr_exec_pkg::OP4_HI:instr_exec_pkg::OP7_LO] == instr_exec_pkg::OP_COPY_ACC;
  endfunction

  function automatic logic is_opt(input logic [instr_exec_pkg::INSTR_W-1:0] w);
    is_opt = w == instr_exec_pkg::OP_OPT_LOAD;
  endfunction

  function automatic logic is_idle(input logic [instr_exec_pkg::INSTR_W-1:0] w);
    is_idle = w == instr_exec_pkg::OP_IDLE;
  endfunction

  // ************************************************************
  // operand fields and file storage
  // ************************************************************
  logic [instr_exec_pkg::DATA_W-1:0]  lit;
  logic [instr_exec_pkg::FADDR_W-1:0] faddr;
  logic [instr_exec_pkg::BIT_W-1:0]   bidx;
  logic [instr_exec_pkg::DATA_W-1:0]  file_mem [instr_exec_pkg::FILE_DEPTH];
  logic [instr_exec_pkg::DATA_W-1:0]  clr_mask;
  logic [instr_exec_pkg::DATA_W-1:0]  and_res;
  logic                               taken;

  // operand slices shared by all opcodes
  always_comb begin
    lit   = instr[instr_exec_pkg::LIT_HI:0];
    faddr = instr[instr_exec_pkg::FADDR_HI:0];
    bidx  = instr[instr_exec_pkg::BIDX_HI:instr_exec_pkg::BIDX_LO];
    taken = instr_valid && !busy;
    and_res = acc & lit;
  end

  // one-cold clear mask built bit by bit, zero only at the bidx position
  genvar gi;
  generate
    for (gi = 0; gi < instr_exec_pkg::DATA_W; gi++) begin : g_mask
      assign clr_mask[gi] = (int'(bidx) != gi); // compared as int, a genvar has no bits to slice
    end
  endgenerate

  // ************************************************************
  // execute state
  // ************************************************************
  instr_exec_pkg::exec_state_t        state;
  instr_exec_pkg::exec_state_t        next_state;
  logic                               next_busy;
  logic [instr_exec_pkg::DATA_W-1:0]  next_acc;
  logic                               next_zero_flag;
  logic [instr_exec_pkg::DATA_W-1:0]  next_option_reg;
  instr_exec_pkg::file_wr_t           next_file_wr;
  instr_exec_pkg::pc_req_t            next_pc_req;

  // next values; unknown opcodes belong to other units and change nothing here
  always_comb begin
    next_state          = instr_exec_pkg::ST_EXEC;
    next_acc            = acc;
    next_zero_flag      = zero_flag;
    next_option_reg     = option_reg;
    next_file_wr        = '0;
    next_pc_req         = '0;
    next_pc_req.value   = pc_req.value;
    case (state)
      instr_exec_pkg::ST_EXEC: begin
        if (taken) begin
          if (is_and_lit(instr)) begin
            next_acc       = and_res;
            next_zero_flag = (and_res == '0);
          end else if (is_bit_clr(instr)) begin
            next_file_wr.en   = 1'b1;
            next_file_wr.addr = faddr;
            next_file_wr.data = file_mem[faddr] & clr_mask;
          end else if (is_copy(instr)) begin
            next_file_wr.en   = 1'b1;
            next_file_wr.addr = faddr;
            next_file_wr.data = acc;
          end else if (is_ret(instr)) begin
            next_acc          = lit;
            next_pc_req.load  = 1'b1;
            next_pc_req.pop   = 1'b1;
            next_pc_req.value = stack_top;
            next_state        = instr_exec_pkg::ST_FLUSH;
          end else if (is_opt(instr)) begin
            next_option_reg = acc;
          end else if (is_idle(instr)) begin
            next_state = instr_exec_pkg::ST_EXEC;
          end
        end
      end
      // second cycle of a return: the prefetched word is discarded
      instr_exec_pkg::ST_FLUSH: begin
        next_state = instr_exec_pkg::ST_EXEC;
      end
      default: begin
        next_state = instr_exec_pkg::ST_EXEC;
      end
    endcase
    next_busy = (next_state == instr_exec_pkg::ST_FLUSH);
  end

  // register the next values
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state      <= instr_exec_pkg::ST_EXEC;
      busy       <= 1'b0;
      acc        <= instr_exec_pkg::ACC_RST;
      zero_flag  <= 1'b0;
      option_reg <= instr_exec_pkg::OPTION_RST;
      file_wr    <= '0;
      pc_req     <= '{load: 1'b0, pop: 1'b0, value: instr_exec_pkg::PC_RST};
    end else begin
      state      <= next_state;
      busy       <= next_busy;
      acc        <= next_acc;
      zero_flag  <= next_zero_flag;
      option_reg <= next_option_reg;
      file_wr    <= next_file_wr;
      pc_req     <= next_pc_req;
    end
  end

  // file storage is data, not control, so it carries no reset
  always_ff @(posedge sys_clk) begin
    if (next_file_wr.en) begin
      file_mem[next_file_wr.addr] <= next_file_wr.data;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_take(logic hit);
    instr_valid && !busy && hit;
  endsequence

  sequence s_two_cycle;
    busy ##1 !busy;
  endsequence

  property p_and_value;
    @(posedge sys_clk) disable iff (!rst_n)
    s_take(is_and_lit(instr)) |=> acc == ($past(acc) & $past(lit))
      && zero_flag == (($past(acc) & $past(lit)) == '0);
  endproperty
  a_and_value: assert property (p_and_value) else $error("literal and wrong");

  property p_and_no_file;
    @(posedge sys_clk) disable iff (!rst_n)
    s_take(is_and_lit(instr)) |=> !file_wr.en && !busy;
  endproperty
  a_and_no_file: assert property (p_and_no_file) else $error("literal and wrote file");

  property p_bit_clr;
    @(posedge sys_clk) disable iff (!rst_n)
    s_take(is_bit_clr(instr)) |=> file_wr.en && file_wr.addr == $past(faddr)
      && file_wr.data == ($past(file_mem[faddr]) & ~(8'h01 << $past(bidx)))
      && $stable(zero_flag) && $stable(acc);
  endproperty
  a_bit_clr: assert property (p_bit_clr) else $error("bit clear wrong");

  property p_copy;
    @(posedge sys_clk) disable iff (!rst_n)
    s_take(is_copy(instr)) |=> file_wr.en && file_wr.data == $past(acc)
      && file_wr.addr == $past(faddr) && $stable(zero_flag) && !busy;
  endproperty
  a_copy: assert property (p_copy) else $error("copy to file wrong");

  property p_ret_acc;
    @(posedge sys_clk) disable iff (!rst_n)
    s_take(is_ret(instr)) |=> acc == $past(lit) && $stable(zero_flag);
  endproperty
  a_ret_acc: assert property (p_ret_acc) else $error("return literal wrong");

  property p_ret_pc;
    @(posedge sys_clk) disable iff (!rst_n)
    s_take(is_ret(instr)) |=> pc_req.load && pc_req.pop
      && pc_req.value == $past(stack_top) ##1 !pc_req.load && !pc_req.pop;
  endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("return pc reload wrong");

  property p_ret_two;
    @(posedge sys_clk) disable iff (!rst_n)
    s_take(is_ret(instr)) |=> s_two_cycle;
  endproperty
  a_ret_two: assert property (p_ret_two) else $error("return not two cycles");

  property p_option;
    @(posedge sys_clk) disable iff (!rst_n)
    s_take(is_opt(instr)) |=> option_reg == $past(acc) && $stable(zero_flag);
  endproperty
  a_option: assert property (p_option) else $error("option load wrong");

  property p_idle;
    @(posedge sys_clk) disable iff (!rst_n)
    s_take(is_idle(instr)) |=> $stable(acc) && $stable(option_reg)
      && !file_wr.en && !pc_req.load;
  endproperty
  a_idle: assert property (p_idle) else $error("idle changed state");

endmodule

`default_nettype wire

// [test/literal_move_return_instr_exec_test.sv]
// self-checking bench for the literal/move/return execute block
`timescale 1ns/1ps
`default_nettype none

module literal_move_return_instr_exec_test;
  logic                                 sys_clk;
  logic                                 rst_n;
  logic                                 instr_valid;
  logic [instr_exec_pkg::INSTR_W-1:0]   instr;
  logic [instr_exec_pkg::PC_W-1:0]      stack_top;
  logic                                 busy;
  logic [instr_exec_pkg::DATA_W-1:0]    acc;
  logic                                 zero_flag;
  logic [instr_exec_pkg::DATA_W-1:0]    option_reg;
  instr_exec_pkg::file_wr_t             file_wr;
  instr_exec_pkg::pc_req_t              pc_req;
  int                                   errors;
  int                                   checks_done;

  instr_exec i_instr_exec (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .instr_valid (instr_valid),
    .instr       (instr),
    .stack_top   (stack_top),
    .busy        (busy),
    .acc         (acc),
    .zero_flag   (zero_flag),
    .option_reg  (option_reg),
    .file_wr     (file_wr),
    .pc_req      (pc_req)
  );

  // ************************************************************
  // clock and helpers
  // ************************************************************
  // 100 MHz core clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1) begin
      errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  // valid stays up so back-to-back words never assign it twice in one step
  task automatic send(input logic [instr_exec_pkg::INSTR_W-1:0] w);
    instr_valid = 1'b1;
    instr = w;
    @(negedge sys_clk);
  endtask

  task automatic idle();
    instr_valid = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_reset();
    check(busy === 1'b0 && acc === 8'h00 && zero_flag === 1'b0, "reset core state");
    check(option_reg === 8'hff && file_wr.en === 1'b0, "reset option or strobe");
    check(pc_req === 11'h000, "reset pc request");
  endtask

  // return, then a word offered in the busy cycle that would zero the accumulator
  task automatic ret(input logic [7:0] k, input logic [8:0] s, input logic z);
    stack_top = s;
    send({4'h8, k});
    check(acc === k && zero_flag === z, "return literal");
    check(pc_req.load === 1'b1 && pc_req.pop === 1'b1, "return pop");
    check(pc_req.value === s, "return pc");
    check(busy === 1'b1, "return busy");
    stack_top = ~s;
    send(12'he00);
    check(busy === 1'b0 && acc === k, "second cycle");
    check(pc_req.load === 1'b0 && pc_req.pop === 1'b0, "pulse ends");
    check(pc_req.value === s, "pc value holds");
    idle();
  endtask

  task automatic test_and_lit();
    send(12'he5f);
    check(acc === 8'h03 && zero_flag === 1'b0 && file_wr.en === 1'b0, "and result");
    send(12'he0c);
    check(acc === 8'h00 && zero_flag === 1'b1 && file_wr.en === 1'b0, "and zero");
    idle();
  endtask

  // every bit index back to back, so a stale read of the file shows at once
  task automatic test_file();
    logic [7:0] exp;
    exp = 8'hff;
    send(12'h025);
    check(file_wr === {1'b1, 5'h05, 8'hff} && zero_flag === 1'b1, "copy");
    for (int b = 0; b < 8; b++) begin
      send({4'h4, b[2:0], 5'h05});
      exp[b] = 1'b0;
      check(file_wr === {1'b1, 5'h05, exp} && zero_flag === 1'b1, "bit clear");
    end
    send(12'h03f);
    check(file_wr === {1'b1, 5'h1f, 8'hff} && acc === 8'hff, "copy top address");
    send(12'h4ff);
    check(file_wr === {1'b1, 5'h1f, 8'h7f} && zero_flag === 1'b1, "bit clear top");
    idle();
    check(file_wr.en === 1'b0, "strobe one cycle");
  endtask

  task automatic test_misc();
    send(12'h000);
    check(acc === 8'h07 && option_reg === 8'hff && file_wr.en === 1'b0, "idle word");
    send(12'h002);
    check(option_reg === 8'h07 && zero_flag === 1'b1 && acc === 8'h07, "option load");
    send(12'h003);
    check(option_reg === 8'h07 && file_wr.en === 1'b0 && pc_req.load === 1'b0, "foreign word");
    idle();
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    errors = 0;
    checks_done = 0;
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr = 12'h000;
    stack_top = 9'h000;
    repeat (16) @(negedge sys_clk);
    test_reset();
    rst_n = 1'b1;
    ret(8'ha3, 9'h1a5, 1'b0);
    test_and_lit();
    ret(8'hff, 9'h003, 1'b1);
    test_file();
    ret(8'h07, 9'h100, 1'b1);
    test_misc();
    final_report();
  end

  // the tests need well under a microsecond; this only cuts a hang short
  initial begin
    #100000;
    errors++;
    final_report();
  end
endmodule

`default_nettype wire
